// *** design/zaa_pkg.sv ***
// Package for the zone alarm annunciator: register map, layouts, constants.
// Assumes a 32-bit APB slave in a single 50 MHz pclk domain.
package zaa_pkg;

  localparam int unsigned ZAA_ZONES = 8;

  // Register byte offsets
  localparam logic [7:0] ZAA_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ZAA_OFF_H24    = 8'h04;
  localparam logic [7:0] ZAA_OFF_LATCH  = 8'h08;
  localparam logic [7:0] ZAA_OFF_DEFARM = 8'h0C;
  localparam logic [7:0] ZAA_OFF_ARMED  = 8'h10;
  localparam logic [7:0] ZAA_OFF_ALARM  = 8'h14;
  localparam logic [7:0] ZAA_OFF_STATUS = 8'h18;
  localparam logic [7:0] ZAA_OFF_INPUTS = 8'h1C;

  // Control register field positions
  localparam int unsigned ZAA_CTRL_SILENCE = 0;
  localparam int unsigned ZAA_CTRL_THREEWAY = 1;

  // Reset values
  localparam logic [1:0] ZAA_CTRL_RST   = 2'h0;
  localparam logic [7:0] ZAA_H24_RST    = 8'h00;
  localparam logic [7:0] ZAA_LATCH_RST  = 8'hFF;
  localparam logic [7:0] ZAA_DEFARM_RST = 8'hFF;

  // Panel inputs that travel together
  typedef struct packed {
    logic [7:0] fault;      // Zone loop faulted
    logic [7:0] arm_btn;    // Primary arm pushbuttons
    logic [7:0] shunt_btn;  // Primary shunt pushbuttons
    logic [7:0] ack_btn;    // Acknowledge pushbuttons
    logic [7:0] rst_btn;    // Zone reset pushbuttons
    logic [7:0] rarm_btn;   // Remote arm requests
    logic [7:0] rshunt_btn; // Remote shunt requests
    logic       master_arm; // Master keyswitch on
    logic       shunt_dis;  // Shunt-disable key
    logic       shunt_mem;  // Shunt-disable with memory key
  } zaa_panel_t;

endpackage

// *** design/zaa_top.sv ***
// Zone alarm annunciator: per-zone alarm, shunt and output logic with APB registers.
// Assumes panel inputs synchronous to pclk and debounced outside this block.
//
// Operation
// - Basic mode: sounder on from any alarm until zone restored and reset
// - Silence mode: acknowledge silences sounder; any new alarm resounds it
// - Shunt-disable key blocks disarm requests; arming still accepted
// - Shunt-disable-with-memory key freezes every zone's arm state
// - One shunt indicator per zone shows armed or disarmed
// - 24-hour zones always armed; shunt requests ignored
// - Latching zone output sets on fault, clears after restore plus reset
// - Non-latching zone output follows the faulted input
// - One active-low individual output per zone
// - Common latching output sets on any fault, clears after restore and reset
// - Common non-latching output on while any input faulted
// - Common audible output on fault, off when alarmed zone acknowledged
// - Common relay output follows any faulted input
// - Shunt common output on while any zone is shunted
// - Master key off: alarms ignored; trouble and tamper still detected
// - Master key off: acknowledge, reset and bypass accepted
// - Master key on: alarms answered; acknowledge, reset, bypass ignored
// - Three-way switching: primary or remote requests share one shunt state
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps

module zaa_top
  import zaa_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Panel inputs
  input  wire zaa_panel_t  panel,
  input  wire logic [7:0]  trouble,
  input  wire logic [7:0]  tamper,
  // Indicators and outputs
  output logic [7:0]       zone_out_n,
  output logic [7:0]       shunt_led,
  output logic [7:0]       trouble_led,
  output logic             com_latch,
  output logic             com_nonlatch,
  output logic             com_audible,
  output logic             com_relay,
  output logic             com_shunt,
  output logic             sounder
);

  // Register state
  logic [1:0]  ctrl_q,   ctrl_d;
  logic [7:0]  h24_q,    h24_d;
  logic [7:0]  latch_q,  latch_d;
  logic [7:0]  defarm_q, defarm_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // Zone state
  zaa_panel_t  prev_q,   prev_d;
  logic        init_q,   init_d;
  logic [7:0]  armed_q,  armed_d;
  logic [7:0]  alarm_q,  alarm_d;
  logic [7:0]  ackd_q,   ackd_d;
  logic [7:0]  zout_q,   zout_d;
  logic [7:0]  shled_q,  shled_d;
  logic [7:0]  trbl_q,   trbl_d;
  logic [5:0]  com_q,    com_d;

  // Rising edge of a button group
  function automatic logic [7:0] zaa_rise(input logic [7:0] now, input logic [7:0] was);
    zaa_rise = now & ~was;
  endfunction

  logic [7:0] arm_req, shunt_req, ack_req, rst_req, live_fault;
  logic       acc, wr, rd;

  // APB access phase: one wait state, registered answer one cycle later
  assign acc = psel & penable & ~pready_q;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;

  // Edge detection of pushbuttons, one action per press
  always_comb
  begin
    logic [7:0] arm_r;
    logic [7:0] shunt_r;
    arm_r     = zaa_rise(panel.arm_btn, prev_q.arm_btn);
    shunt_r   = zaa_rise(panel.shunt_btn, prev_q.shunt_btn);
    if (ctrl_q[ZAA_CTRL_THREEWAY])
    begin
      arm_r   = arm_r | zaa_rise(panel.rarm_btn, prev_q.rarm_btn);
      shunt_r = shunt_r | zaa_rise(panel.rshunt_btn, prev_q.rshunt_btn);
    end
    arm_req   = arm_r;
    shunt_req = shunt_r;
    ack_req   = zaa_rise(panel.ack_btn, prev_q.ack_btn);
    rst_req   = zaa_rise(panel.rst_btn, prev_q.rst_btn);
    // Master key off: pushbutton ack, reset and bypass count
    if (panel.master_arm)
    begin
      ack_req   = 8'h00;
      rst_req   = 8'h00;
      shunt_req = 8'h00;
    end
    // Alarms count only while armed by the key, and in armed zones
    live_fault = panel.master_arm ? (panel.fault & armed_q) : 8'h00;
  end

  // Zone next-state logic
  always_comb
  begin
    logic [7:0] new_alarm;
    new_alarm = 8'h00;
    prev_d  = panel;
    init_d  = 1'b1;
    armed_d = armed_q;
    // Default arm state taken once after reset release
    if (!init_q)
    begin
      armed_d = defarm_q | h24_q;
    end
    else if (!panel.shunt_mem)
    begin
      armed_d = armed_q | arm_req;
      if (!panel.shunt_dis)
      begin
        armed_d = armed_d & ~shunt_req;
      end
    end
    armed_d = armed_d | h24_q;

    // Alarm latches; a reset only clears a restored zone, set wins
    new_alarm = live_fault & ~alarm_q;
    alarm_d   = (alarm_q & ~(rst_req & ~panel.fault)) | live_fault;
    ackd_d    = (ackd_q | (ack_req & alarm_q)) & alarm_d & ~new_alarm;

    // Individual outputs, active low
    for (int i = 0; i < ZAA_ZONES; i++)
    begin
      if (latch_q[i])
        zout_d[i] = ~alarm_d[i];
      else
        zout_d[i] = ~live_fault[i];
    end
    shled_d = ~armed_d;
    trbl_d  = trouble | tamper;

    // Common outputs: latch, nonlatch, audible, relay, shunt, sounder
    com_d[0] = |alarm_d;
    com_d[1] = |live_fault;
    com_d[2] = |(alarm_d & ~ackd_d);
    com_d[3] = |live_fault;
    com_d[4] = |(~armed_d);
    if (ctrl_q[ZAA_CTRL_SILENCE])
      com_d[5] = |(alarm_d & ~ackd_d);
    else
      com_d[5] = |alarm_d;
  end

  // Register file next-state and read mux
  always_comb
  begin
    ctrl_d    = ctrl_q;
    h24_d     = h24_q;
    latch_d   = latch_q;
    defarm_d  = defarm_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = acc;
    pslverr_d = 1'b0;
    if (wr)
    begin
      unique case (paddr)
        ZAA_OFF_CTRL:   ctrl_d   = pwdata[1:0];
        ZAA_OFF_H24:    h24_d    = pwdata[7:0];
        ZAA_OFF_LATCH:  latch_d  = pwdata[7:0];
        ZAA_OFF_DEFARM: defarm_d = pwdata[7:0];
        ZAA_OFF_ARMED, ZAA_OFF_ALARM, ZAA_OFF_STATUS, ZAA_OFF_INPUTS: ;
        default:        pslverr_d = 1'b1;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        ZAA_OFF_CTRL:   prdata_d = {30'h0, ctrl_q};
        ZAA_OFF_H24:    prdata_d = {24'h0, h24_q};
        ZAA_OFF_LATCH:  prdata_d = {24'h0, latch_q};
        ZAA_OFF_DEFARM: prdata_d = {24'h0, defarm_q};
        ZAA_OFF_ARMED:  prdata_d = {24'h0, armed_q};
        ZAA_OFF_ALARM:  prdata_d = {16'h0, ackd_q, alarm_q};
        ZAA_OFF_STATUS: prdata_d = {26'h0, com_q[5:0]};
        ZAA_OFF_INPUTS: prdata_d = {21'h0, panel.master_arm, panel.shunt_dis,
                                    panel.shunt_mem, panel.fault};
        default:        pslverr_d = 1'b1;
      endcase
    end
  end

  // State registers; every flop reset to a constant
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= ZAA_CTRL_RST;
      h24_q     <= ZAA_H24_RST;
      latch_q   <= ZAA_LATCH_RST;
      defarm_q  <= ZAA_DEFARM_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prev_q    <= '0;
      init_q    <= 1'b0;
      armed_q   <= 8'h00;
      alarm_q   <= 8'h00;
      ackd_q    <= 8'h00;
      zout_q    <= 8'hFF;
      shled_q   <= 8'h00;
      trbl_q    <= 8'h00;
      com_q     <= 6'h00;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      h24_q     <= h24_d;
      latch_q   <= latch_d;
      defarm_q  <= defarm_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prev_q    <= prev_d;
      init_q    <= init_d;
      armed_q   <= armed_d;
      alarm_q   <= alarm_d;
      ackd_q    <= ackd_d;
      zout_q    <= zout_d;
      shled_q   <= shled_d;
      trbl_q    <= trbl_d;
      com_q     <= com_d;
    end
  end

  // Outputs straight from flops
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign zone_out_n   = zout_q;
  assign shunt_led    = shled_q;
  assign trouble_led  = trbl_q;
  assign com_latch    = com_q[0];
  assign com_nonlatch = com_q[1];
  assign com_audible  = com_q[2];
  assign com_relay    = com_q[3];
  assign com_shunt    = com_q[4];
  assign sounder      = com_q[5];

endmodule // zaa_top

// *** verification/zaa_assertions.sv ***
// Checker for the zone alarm annunciator, bound to the top module's ports.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/100ps
module zaa_assertions
  import zaa_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Panel and outputs
  input wire zaa_panel_t panel,
  input wire logic [7:0] shunt_led,
  input wire logic       com_latch,
  input wire logic       com_nonlatch,
  input wire logic       com_audible,
  input wire logic       com_relay,
  input wire logic       com_shunt,
  input wire logic       sounder
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state, then the answer
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  // Restored loops drop the following outputs
  property p_relay; panel.fault == 8'h00 |=> !com_relay; endproperty
  a_relay: assert property (p_relay) else $error("relay stuck");
  property p_nonl; panel.fault == 8'h00 |=> !com_nonlatch; endproperty
  a_nonl: assert property (p_nonl) else $error("nonlatch stuck");
  // Latched outputs only fall on a reset or acknowledge press
  property p_latch; com_latch && panel.rst_btn == 8'h00 |=> com_latch; endproperty
  a_latch: assert property (p_latch) else $error("latch dropped");
  property p_aud;
    com_audible && panel.ack_btn == 8'h00 && panel.rst_btn == 8'h00 |=> com_audible;
  endproperty
  a_aud: assert property (p_aud) else $error("audible dropped");
  property p_sound;
    sounder && panel.ack_btn == 8'h00 && panel.rst_btn == 8'h00 |=> sounder;
  endproperty
  a_sound: assert property (p_sound) else $error("sounder dropped");
  // Common shunt output mirrors the indicators
  property p_shunt; com_shunt == (shunt_led != 8'h00); endproperty
  a_shunt: assert property (p_shunt) else $error("shunt common wrong");
  // Two cycles of memory key cover any pipeline stage
  property p_frz; panel.shunt_mem [*2] |=> $stable(shunt_led); endproperty
  a_frz: assert property (p_frz) else $error("frozen state moved");

  c_alarm: cover property ($rose(sounder));
  c_shunt: cover property ($rose(com_shunt));
  c_clear: cover property ($fell(com_latch));
endmodule // zaa_assertions

bind zaa_top zaa_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .panel(panel), .shunt_led(shunt_led),
  .com_latch(com_latch), .com_nonlatch(com_nonlatch), .com_audible(com_audible),
  .com_relay(com_relay), .com_shunt(com_shunt), .sounder(sounder));

// *** verification/zaa_panel_model.sv ***
// Model of loops, key switches and pushbuttons facing the annunciator.
// Assumes the bench calls its tasks between rising edges of pclk.
`timescale 1ns/100ps
module zaa_panel_model
  import zaa_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Panel lines
  output zaa_panel_t panel
);
  initial panel = '0;

  // Loop and key levels, settled before return
  task automatic lv(input logic [7:0] f, input logic [2:0] k);
    @(posedge pclk);
    panel.fault <= f;
    {panel.master_arm, panel.shunt_dis, panel.shunt_mem} <= k;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Held two edges then released: one rising edge per press
  task automatic press(input int k, input logic [7:0] m);
    @(posedge pclk);
    panel[50 - 8 * k -: 8] <= m;
    repeat (2) @(posedge pclk);
    panel[50:3] <= '0; // All buttons released
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
endmodule // zaa_panel_model

// *** verification/zaa_tb_top.sv ***
// Testbench for the zone alarm annunciator: APB and panel scenarios.
// Assumes the panel model drives loops, keys and buttons.
`timescale 1ns/100ps
module zaa_tb_top
  import zaa_pkg::*;
;
  localparam int ARM = 0, SHB = 1, ACK = 2, RST = 3, RARM = 4, RSHB = 5;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00, trouble = 8'h00, tamper = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, com_latch, com_nonlatch, com_audible, com_relay;
  logic        com_shunt, sounder;
  logic [7:0]  zone_out_n, shunt_led, trouble_led;
  zaa_panel_t  panel;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  logic [7:0]  offs [5] = '{ZAA_OFF_CTRL, ZAA_OFF_H24, ZAA_OFF_LATCH, ZAA_OFF_DEFARM,
                            ZAA_OFF_ARMED};
  logic [31:0] exps [5] = '{32'h0, 32'h0, 32'hFF, 32'hFF, 32'hFF};
  wire  [31:0] st = {26'h0, sounder, com_shunt, com_relay, com_audible, com_nonlatch,
                     com_latch};

  always #10 pclk = ~pclk;

  zaa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel(panel), .trouble(trouble), .tamper(tamper),
    .zone_out_n(zone_out_n), .shunt_led(shunt_led), .trouble_led(trouble_led),
    .com_latch(com_latch), .com_nonlatch(com_nonlatch), .com_audible(com_audible),
    .com_relay(com_relay), .com_shunt(com_shunt), .sounder(sounder));
  zaa_panel_model m (.pclk(pclk), .panel(panel));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask

  task automatic results;
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the scenario length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    chk(zone_out_n, 8'hFF);
    chk(st, 32'h0);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, exps[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ZAA_OFF_LATCH, 32'h0F);
    apb(1'b1, ZAA_OFF_H24, 32'h80);
    @(posedge pclk);
    {trouble, tamper} <= 16'h0330;
    m.lv(8'h00, 3'h0);
    chk(trouble_led, 8'h33);
    m.press(SHB, 8'hFF);
    chk(shunt_led, 8'h7F);
    m.lv(8'h00, 3'h2);
    m.press(ARM, 8'h01);
    m.press(SHB, 8'h03);
    chk(shunt_led, 8'h7E);
    m.lv(8'h00, 3'h1);
    m.press(ARM, 8'h02);
    m.press(SHB, 8'h01);
    chk(shunt_led, 8'h7E);
    m.lv(8'h00, 3'h0);
    apb(1'b1, ZAA_OFF_CTRL, 32'h2);
    m.press(RSHB, 8'h01);
    chk(shunt_led, 8'h7F);
    m.press(RARM, 8'hFF);
    chk(st, 32'h0);
    m.lv(8'h11, 3'h4);
    chk(zone_out_n, 8'hEE);
    chk(st, 32'h2F);
    apb(1'b0, ZAA_OFF_ALARM, 32'h0);
    chk(rd, 32'h0000_0011);
    m.press(ACK, 8'h11);
    chk(st, 32'h2F);
    m.lv(8'h00, 3'h4);
    chk(zone_out_n, 8'hFE);
    chk(st, 32'h25);
    m.press(RST, 8'h01);
    chk(zone_out_n, 8'hFE);
    m.lv(8'hFF, 3'h0);
    chk(zone_out_n, 8'hFE);
    m.lv(8'h00, 3'h0);
    m.press(RST, 8'h11);
    chk(zone_out_n, 8'hFF);
    chk(st & 32'h21, 32'h0);
    m.press(ACK, 8'h11);
    chk(com_audible, 1'h0);
    apb(1'b1, ZAA_OFF_CTRL, 32'h1);
    m.lv(8'h02, 3'h4);
    m.lv(8'h00, 3'h0);
    m.press(ACK, 8'h02);
    chk(sounder, 1'h0);
    m.lv(8'h04, 3'h4);
    chk(sounder, 1'h1);
    results();
  end
endmodule // zaa_tb_top
